// >>> core/fsg_regs.vh
// Register offsets, field positions, reset values and constants of the Flash guard
`ifndef FSG_REGS_VH
`define FSG_REGS_VH
// ***********************
// Register offsets
// ***********************
`define FSG_OFF_PSTORE_CTRL 8'h00
`define FSG_OFF_UNLOCK_KEY 8'h01
`define FSG_OFF_RESET_CAUSE 8'h02
`define FSG_OFF_SUPPLY_MON 8'h03
`define FSG_OFF_STATUS 8'h04
// ***********************
// Field positions
// ***********************
`define FSG_BIT_WRITE_EN 0
`define FSG_BIT_ERASE_EN 1
`define FSG_BIT_FAULT_FLAG 6
`define FSG_BIT_MON_EN 0
`define FSG_BIT_MON_RST_EN 1
// ***********************
// Reset values and codes
// ***********************
`define FSG_PSTORE_CTRL_RST 8'h00
`define FSG_SUPPLY_MON_RST 8'h00
`define FSG_KEY_FIRST 8'hA5
`define FSG_KEY_SECOND 8'hF1
`define FSG_LOCK_ERASED 8'hFF
// ***********************
// Address map of the Flash array
// ***********************
`define FSG_PAGE_LSB 10
`define FSG_LOCK_BYTE_ADDR 15'h7BFF
`define FSG_LOCK_PAGE 5'h1E
`define FSG_RSVD_PAGE 5'h1F
`define FSG_NUM_PAGES 32
`define FSG_TARGET_SOURCE 2'h0
`define FSG_TARGET_FW_UNLOCKED 2'h1
`define FSG_TARGET_FW_LOCKED 2'h2
// ***********************
// Access sources and kinds
// ***********************
`define FSG_SRC_DEBUG 1'b1
`define FSG_OP_READ 2'h0
`define FSG_OP_WRITE 2'h1
`define FSG_OP_ERASE 2'h2
`define FSG_OP_CHIP_ERASE 2'h3
`endif

// >>> core/fsg_key_seq.v
// Two-code unlock key sequencer for Flash write and erase
`timescale 1ns/10ps
module fsg_key_seq (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_b_in,
  // Key register writes
  input wire key_wr_in,
  input wire [7:0] key_data_in,
  // Operation attempt
  input wire op_attempt_in,
  // Key state
  output wire armed_out,
  output wire [1:0] key_state_out
);
`include "fsg_regs.vh"
  localparam ST_IDLE = 4'b0001;
  localparam ST_HALF = 4'b0010;
  localparam ST_ARMED = 4'b0100;
  localparam ST_DEAD = 4'b1000;
  reg [3:0] state_q;
  reg [3:0] state_d;
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (op_attempt_in) begin
          state_d = ST_DEAD;
        end else if (key_wr_in) begin
          state_d = (key_data_in == `FSG_KEY_FIRST) ? ST_HALF : ST_DEAD;
        end
      end
      ST_HALF: begin
        if (op_attempt_in) begin
          state_d = ST_DEAD;
        end else if (key_wr_in) begin
          state_d = (key_data_in == `FSG_KEY_SECOND) ? ST_ARMED : ST_DEAD;
        end
      end
      ST_ARMED: begin
        // One operation per key sequence
        if (op_attempt_in) begin
          state_d = ST_IDLE;
        end else if (key_wr_in) begin
          state_d = ST_DEAD;
        end
      end
      ST_DEAD: state_d = ST_DEAD;
      default: state_d = ST_DEAD;
    endcase
  end
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end
  assign armed_out = state_q[2];
  assign key_state_out = state_q[3] ? 2'h3 : (state_q[2] ? 2'h2 : (state_q[1] ? 2'h1 : 2'h0));
endmodule

// >>> core/fsg_page_judge.v
// Judges one Flash access against lock byte, page map and access source
`timescale 1ns/10ps
module fsg_page_judge (
  // Lock state in force
  input wire [7:0] lock_byte_in,
  // Access description
  input wire src_debug_in,
  input wire [1:0] op_in,
  input wire [14:0] addr_in,
  input wire [14:0] exec_addr_in,
  input wire [7:0] wdata_in,
  // Verdict
  output reg allow_out,
  output reg fault_out
);
`include "fsg_regs.vh"
  reg [4:0] tgt_page;
  reg [4:0] exec_page;
  reg [7:0] lock_count;
  reg any_locked;
  reg tgt_locked;
  reg exec_locked;
  reg forbid;
  reg lock_byte_hit;
  always @* begin
    tgt_page = addr_in[14:`FSG_PAGE_LSB];
    exec_page = exec_addr_in[14:`FSG_PAGE_LSB];
    lock_count = ~lock_byte_in;
    any_locked = (lock_byte_in != `FSG_LOCK_ERASED);
    tgt_locked = ({3'h0, tgt_page} < lock_count) || ((tgt_page == `FSG_LOCK_PAGE) && any_locked);
    exec_locked = ({3'h0, exec_page} < lock_count) || ((exec_page == `FSG_LOCK_PAGE) && any_locked);
    lock_byte_hit = (addr_in == `FSG_LOCK_BYTE_ADDR);
    forbid = 1'b0;
    allow_out = 1'b0;
    fault_out = 1'b0;
    if (op_in == `FSG_OP_CHIP_ERASE) begin
      allow_out = src_debug_in;
      fault_out = ~src_debug_in;
    end else begin
      if (tgt_page == `FSG_RSVD_PAGE) begin
        forbid = 1'b1;
        fault_out = ~src_debug_in;
      end else if ((tgt_page == `FSG_LOCK_PAGE) && (op_in == `FSG_OP_ERASE)) begin
        // Page erase of the lock page is only legal from debug with nothing locked
        forbid = ~src_debug_in || any_locked;
        fault_out = ~src_debug_in;
      end else if (lock_byte_hit && (op_in == `FSG_OP_WRITE)) begin
        // Once programmed, the lock byte never changes short of a chip erase
        if (src_debug_in || any_locked || (wdata_in != `FSG_LOCK_ERASED)) begin
          forbid = src_debug_in || any_locked;
          fault_out = ~src_debug_in && any_locked;
        end
      end else if (tgt_locked) begin
        forbid = src_debug_in || ~exec_locked;
        fault_out = ~src_debug_in && ~exec_locked;
      end
      allow_out = ~forbid;
      fault_out = fault_out && forbid && ~src_debug_in;
    end
  end
endmodule

// >>> core/fsg_guard.v
// Flash security and write guard: register file, access arbitration and fault reset
//
// Behaviour
// - Software modification needs write enable set
// - Software erase needs write and erase enables
// - Lock byte complement gives locked page count
// - Lock page locked once any lock bit clears
// - Unlocked pages open to every source
// - Locked pages: debug refused, unlocked firmware faults
// - Lock page guarded likewise when anything locked
// - Lock page erase: debug only, nothing locked
// - Debug chip erase alone removes the lock
// - Lock byte changes refused or faulted
// - Reserved area refused to debug, faults firmware
// - Fault flag reads one after fault reset
// - Debug violations ignored, never reset
// - Written lock byte fixed until chip erase
// - New lock byte applies after next reset
// - Modification without supply monitor faults
// - Interrupts held during program or erase
// - Bad key sequence disables until reset
// - Key relocks after every operation
// - Top 1024 bytes from 0x7C00 reserved
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module fsg_guard (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_b_in,
  // Register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // Flash access request
  input wire acc_req_in,
  input wire acc_src_debug_in,
  input wire [1:0] acc_op_in,
  input wire [14:0] acc_addr_in,
  input wire [14:0] acc_exec_addr_in,
  input wire [7:0] acc_wdata_in,
  // Current lock byte value from the Flash array
  input wire [7:0] lock_byte_in,
  // Flash array command and verdict
  output reg flash_go_out,
  output reg [1:0] flash_op_out,
  output reg [14:0] flash_addr_out,
  output reg [7:0] flash_wdata_out,
  output reg acc_refused_out,
  // Flash busy from the array
  input wire flash_busy_in,
  // Interrupt hold during program or erase
  output reg irq_hold_out,
  // Flash fault device reset request
  output reg flash_fault_device_reset_out
);
`include "fsg_regs.vh"
  // ***********************
  // Reset synchroniser
  // ***********************
  reg rst_meta_q;
  reg rst_sync_q;
  wire fw_fault;
  // A firmware fault pulls the internal reset low for one cycle
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= ~fw_fault;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire rst_b = rst_sync_q;

  // ***********************
  // Registers
  // ***********************
  reg [7:0] pstore_ctrl_q;
  reg [1:0] supply_mon_q;
  reg flash_fault_flag_q;
  reg [7:0] lock_eff_q;
  reg lock_cap_q;
  reg fault_pend_q;
  wire store_write_enable = pstore_ctrl_q[`FSG_BIT_WRITE_EN];
  wire store_erase_enable = pstore_ctrl_q[`FSG_BIT_ERASE_EN];
  wire supply_ok = supply_mon_q[`FSG_BIT_MON_EN] & supply_mon_q[`FSG_BIT_MON_RST_EN];

  wire key_wr = reg_wr_in && (reg_addr_in == `FSG_OFF_UNLOCK_KEY);
  wire armed;
  wire [1:0] key_state;
  wire allow;
  wire judge_fault;

  // ***********************
  // Firmware modification qualification
  // ***********************
  wire fw_req = acc_req_in && (acc_src_debug_in != `FSG_SRC_DEBUG);
  wire fw_modify = fw_req && store_write_enable && (acc_op_in != `FSG_OP_READ);
  // A write strobe with both enables set becomes a page erase
  wire [1:0] fw_op = (acc_op_in == `FSG_OP_READ) ? `FSG_OP_READ :
                     (store_erase_enable ? `FSG_OP_ERASE : `FSG_OP_WRITE);
  wire [1:0] eff_op = acc_src_debug_in ? acc_op_in : fw_op;
  // Writes with the enable clear go to data memory, not Flash
  wire fw_ignored = fw_req && (acc_op_in != `FSG_OP_READ) && !store_write_enable;

  fsg_key_seq u_key (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b),
    .key_wr_in(key_wr),
    .key_data_in(reg_wdata_in),
    .op_attempt_in(fw_modify),
    .armed_out(armed),
    .key_state_out(key_state)
  );

  fsg_page_judge u_judge (
    .lock_byte_in(lock_eff_q),
    .src_debug_in(acc_src_debug_in),
    .op_in(eff_op),
    .addr_in(acc_addr_in),
    .exec_addr_in(acc_exec_addr_in),
    .wdata_in(acc_wdata_in),
    .allow_out(allow),
    .fault_out(judge_fault)
  );

  // Supply monitor must guard every firmware modification
  wire supply_fault = fw_modify && !supply_ok;
  assign fw_fault = fw_req && !fw_ignored && (judge_fault || supply_fault);
  // Unkeyed attempts are refused silently; the key logic then locks out
  wire go = acc_req_in && !fw_ignored && allow && !fw_fault && !flash_busy_in &&
            (acc_src_debug_in || !fw_modify || armed);

  // ***********************
  // Lock byte capture after each reset
  // ***********************
  always @(posedge core_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      lock_cap_q <= 1'b0;
      lock_eff_q <= `FSG_LOCK_ERASED;
    end else begin
      if (!lock_cap_q) begin
        lock_cap_q <= 1'b1;
        lock_eff_q <= lock_byte_in;
      end else if (go && acc_src_debug_in && (acc_op_in == `FSG_OP_CHIP_ERASE)) begin
        lock_eff_q <= `FSG_LOCK_ERASED;
      end
    end
  end

  // ***********************
  // Register writes
  // ***********************
  always @(posedge core_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      pstore_ctrl_q <= `FSG_PSTORE_CTRL_RST;
      supply_mon_q <= 2'h0;
    end else begin
      if (reg_wr_in && (reg_addr_in == `FSG_OFF_PSTORE_CTRL)) begin
        pstore_ctrl_q <= {6'h00, reg_wdata_in[1:0]};
      end
      if (reg_wr_in && (reg_addr_in == `FSG_OFF_SUPPLY_MON)) begin
        supply_mon_q <= reg_wdata_in[1:0];
      end
    end
  end

  // ***********************
  // Fault flag survives only the fault reset it caused
  // ***********************
  // Held on the raw reset so a fault reset does not erase its own cause
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fault_pend_q <= 1'b0;
      flash_fault_flag_q <= 1'b0;
    end else begin
      if (fw_fault) begin
        fault_pend_q <= 1'b1;
      end else if (!rst_b) begin
        fault_pend_q <= 1'b0;
      end
      if (!rst_b && fault_pend_q) begin
        flash_fault_flag_q <= 1'b1;
      end else if (fw_fault) begin
        flash_fault_flag_q <= 1'b0;
      end
    end
  end

  // ***********************
  // Outputs
  // ***********************
  always @(posedge core_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      flash_go_out <= 1'b0;
      flash_op_out <= `FSG_OP_READ;
      flash_addr_out <= 15'h0000;
      flash_wdata_out <= 8'h00;
      acc_refused_out <= 1'b0;
      irq_hold_out <= 1'b0;
      flash_fault_device_reset_out <= 1'b0;
      reg_rdata_out <= 8'h00;
    end else begin
      flash_go_out <= go;
      flash_op_out <= eff_op;
      flash_addr_out <= acc_addr_in;
      flash_wdata_out <= acc_wdata_in;
      acc_refused_out <= acc_req_in && !go && !fw_fault;
      flash_fault_device_reset_out <= fw_fault;
      // Interrupts wait while the array programs or erases
      irq_hold_out <= flash_busy_in || (go && (eff_op != `FSG_OP_READ));
      reg_rdata_out <= 8'h00;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `FSG_OFF_PSTORE_CTRL: reg_rdata_out <= pstore_ctrl_q;
          `FSG_OFF_UNLOCK_KEY: reg_rdata_out <= {6'h00, key_state};
          `FSG_OFF_RESET_CAUSE: reg_rdata_out <= {1'b0, flash_fault_flag_q, 6'h00};
          `FSG_OFF_SUPPLY_MON: reg_rdata_out <= {6'h00, supply_mon_q};
          `FSG_OFF_STATUS: reg_rdata_out <= lock_eff_q;
          default: reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end
endmodule

// >>> verif/fsg_flash_model.sv
// Behavioural Flash array seen by the guard: busy timing and lock byte
`timescale 1ns/10ps
module fsg_flash_model (
  // Clock
  input wire core_clk_in,
  // Command from the guard
  input wire go_in,
  input wire [1:0] op_in,
  input wire [14:0] addr_in,
  input wire [7:0] wdata_in,
  // Array state
  output reg busy_out,
  output reg [7:0] lock_out
);
  reg [1:0] cnt_q;
  // Non-volatile: lock byte survives every reset
  initial begin
    cnt_q = 2'h0;
    busy_out = 1'b0;
    lock_out = 8'hff;
  end
  always @(posedge core_clk_in) begin
    if (go_in)
      cnt_q <= 2'h3;
    else if (cnt_q != 2'h0)
      cnt_q <= cnt_q - 2'h1;
    busy_out <= go_in || cnt_q > 2'h1;
    if (go_in && op_in == 2'h3)
      lock_out <= 8'hff;
    // Programming only clears bits
    if (go_in && op_in == 2'h1 && addr_in == 15'h7bff)
      lock_out <= lock_out & wdata_in;
  end
endmodule

// >>> verif/fsg_guard_monitor.sv
// Concurrent checks on the Flash guard ports
`timescale 1ns/10ps
module fsg_guard_monitor (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_b_in,
  // Observed ports
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire acc_req_in,
  input wire acc_src_debug_in,
  input wire [1:0] acc_op_in,
  input wire [14:0] acc_addr_in,
  input wire flash_go_out,
  input wire [14:0] flash_addr_out,
  input wire acc_refused_out,
  input wire flash_busy_in,
  input wire irq_hold_out,
  input wire flash_fault_device_reset_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  wire rsv = acc_req_in && acc_addr_in[14:10] == 5'h1f && !flash_busy_in;
  wire dbg = acc_req_in && acc_src_debug_in;
  wire [2:0] ans = {flash_go_out, acc_refused_out, flash_fault_device_reset_out};
  property p_one; acc_req_in |=> $onehot0(ans); endproperty
  a_one: assert property (p_one) else $error("two answers");
  property p_dbg_nf; dbg |=> !flash_fault_device_reset_out; endproperty
  a_dbg_nf: assert property (p_dbg_nf) else $error("debug reset");
  property p_busy; dbg && flash_busy_in |=> acc_refused_out; endproperty
  a_busy: assert property (p_busy) else $error("busy granted");
  property p_drsv; rsv && acc_src_debug_in && acc_op_in != 2'h3 |=> acc_refused_out; endproperty
  a_drsv: assert property (p_drsv) else $error("reserved debug");
  property p_frsv; rsv && !acc_src_debug_in && acc_op_in == 2'h0 |=> flash_fault_device_reset_out; endproperty
  a_frsv: assert property (p_frsv) else $error("reserved fw");
  property p_ce; dbg && acc_op_in == 2'h3 && !flash_busy_in |=> flash_go_out; endproperty
  a_ce: assert property (p_ce) else $error("chip erase");
  property p_addr; flash_go_out |-> flash_addr_out == $past(acc_addr_in) && $past(acc_req_in); endproperty
  a_addr: assert property (p_addr) else $error("go address");
  property p_rdz; !$past(reg_rd_in) |-> reg_rdata_out == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("read data idle");
  property p_irq; flash_busy_in |=> irq_hold_out; endproperty
  a_irq: assert property (p_irq) else $error("irq not held");
  c_go: cover property (flash_go_out);
  c_ref: cover property (acc_refused_out);
  c_flt: cover property (flash_fault_device_reset_out);
endmodule
bind fsg_guard fsg_guard_monitor u_mon (.*);

// >>> verif/flash_security_write_guard_tb.sv
// Self-checking bench of the Flash guard
`timescale 1ns/10ps
`include "fsg_regs.vh"
`define CHK(a, e) begin comparisons = comparisons + 1; if ((a) !== (e)) begin \
  bad_count = bad_count + 1; $display("mismatch at %0t: %h not %h", $time, a, e); end end
module flash_security_write_guard_tb;
  reg core_clk_in = 1'b0;
  reg rst_b_in = 1'b0;
  reg [7:0] reg_addr_in = 8'h00;
  reg [7:0] reg_wdata_in = 8'h00;
  reg reg_wr_in = 1'b0;
  reg reg_rd_in = 1'b0;
  reg acc_req_in = 1'b0;
  reg acc_src_debug_in = 1'b0;
  reg [1:0] acc_op_in = 2'h0;
  reg [14:0] acc_addr_in = 15'h0000;
  reg [14:0] acc_exec_addr_in = 15'h0000;
  reg [7:0] acc_wdata_in = 8'h00;
  wire [7:0] reg_rdata_out, lock_byte_in, flash_wdata_out;
  wire [14:0] flash_addr_out;
  wire [1:0] flash_op_out;
  wire flash_go_out, acc_refused_out, flash_busy_in, irq_hold_out, flash_fault_device_reset_out;
  integer bad_count = 0;
  integer comparisons = 0;
  reg [7:0] rv;
  reg [2:0] v;
  reg [1:0] op_seen;
  localparam [2:0] GO = 3'h4, REF = 3'h2, FLT = 3'h1;
  fsg_guard uut (.*);
  fsg_flash_model model (.core_clk_in(core_clk_in), .go_in(flash_go_out), .op_in(flash_op_out),
    .addr_in(flash_addr_out), .wdata_in(flash_wdata_out), .busy_out(flash_busy_in), .lock_out(lock_byte_in));
  always #50 core_clk_in = ~core_clk_in;
  // ****
  // Bus and access tasks
  // ****
  task tick;
    @(posedge core_clk_in);
  endtask
  task conclude;
    begin
      if (bad_count == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      tick;
      reg_wr_in <= 1'b0;
      // Gap cycle: the strobe is never assigned twice in one step
      tick;
    end
  endtask
  task rd(input [7:0] a);
    begin
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      tick;
      reg_rd_in <= 1'b0;
      #1 rv = reg_rdata_out;
      tick;
    end
  endtask
  task key;
    begin
      wr(8'h01, `FSG_KEY_FIRST);
      wr(8'h01, `FSG_KEY_SECOND);
    end
  endtask
  task idle;
    integer i;
    begin
      tick;
      #1;
      for (i = 0; i < 20 && flash_busy_in !== 1'b0; i = i + 1) begin
        tick;
        #1;
      end
      // Hung array would stall every later check
      if (flash_busy_in !== 1'b0) begin
        $display("mismatch at %0t: array stuck busy", $time);
        bad_count = bad_count + 1;
        conclude;
      end
      tick;
    end
  endtask
  task acc(input dbg, input [1:0] op, input [14:0] a, input [14:0] x, input [7:0] d, input w);
    begin
      acc_src_debug_in <= dbg;
      acc_op_in <= op;
      acc_addr_in <= a;
      acc_exec_addr_in <= x;
      acc_wdata_in <= d;
      acc_req_in <= 1'b1;
      tick;
      acc_req_in <= 1'b0;
      #1 v = {flash_go_out, acc_refused_out, flash_fault_device_reset_out};
      op_seen = flash_op_out;
      if (w)
        idle;
    end
  endtask
  task do_reset;
    begin
      rst_b_in <= 1'b0;
      repeat (2) tick;
      rst_b_in <= 1'b1;
      repeat (4) tick;
    end
  endtask
  // ****
  // Scenarios
  // ****
  task t_regs;
    begin
      rd(8'h00);
      `CHK(rv, 8'h00)
      rd(8'h03);
      `CHK(rv, 8'h00)
      rd(8'h10);
      `CHK(rv, 8'h00)
      rd(8'h04);
      `CHK(rv, 8'hff)
    end
  endtask
  task t_busy;
    begin
      acc(1'b1, 2'h0, 15'h0000, 15'h0000, 8'h00, 1'b0);
      `CHK(v, GO)
      tick;
      acc(1'b1, 2'h0, 15'h0000, 15'h0000, 8'h00, 1'b1);
      `CHK(v, REF)
    end
  endtask
  task t_wen;
    begin
      key;
      wr(8'h03, 8'h03);
      wr(8'h00, 8'h00);
      acc(1'b0, 2'h1, 15'h0400, 15'h0000, 8'h5a, 1'b1);
      `CHK(v, REF)
      wr(8'h00, 8'h01);
      acc(1'b0, 2'h1, 15'h0400, 15'h0000, 8'h5a, 1'b1);
      `CHK(v, GO)
      acc(1'b0, 2'h1, 15'h0401, 15'h0000, 8'h5a, 1'b1);
      `CHK(v, REF)
      key;
      acc(1'b0, 2'h1, 15'h0401, 15'h0000, 8'h5a, 1'b1);
      `CHK(v, REF)
      rd(8'h01);
      `CHK(rv, 8'h03)
    end
  endtask
  task t_erase;
    begin
      do_reset;
      key;
      wr(8'h03, 8'h03);
      wr(8'h00, 8'h03);
      acc(1'b0, 2'h1, 15'h0400, 15'h0000, 8'h00, 1'b1);
      `CHK(v, GO)
      `CHK(op_seen, `FSG_OP_ERASE)
      acc(1'b1, 2'h2, 15'h7800, 15'h0000, 8'h00, 1'b1);
      `CHK(v, GO)
      key;
      acc(1'b0, 2'h1, 15'h7800, 15'h0000, 8'h00, 1'b1);
      `CHK(v, FLT)
    end
  endtask
  task t_mon;
    begin
      key;
      wr(8'h03, 8'h01);
      wr(8'h00, 8'h01);
      acc(1'b0, 2'h1, 15'h0400, 15'h0000, 8'h00, 1'b1);
      `CHK(v, FLT)
      rd(8'h02);
      `CHK(rv[6], 1'b1)
      rd(8'h00);
      `CHK(rv, 8'h00)
      acc(1'b1, 2'h0, 15'h7c00, 15'h0000, 8'h00, 1'b1);
      `CHK(v, REF)
      acc(1'b0, 2'h0, 15'h7c10, 15'h0000, 8'h00, 1'b1);
      `CHK(v, FLT)
    end
  endtask
  task t_lock;
    begin
      acc(1'b1, 2'h1, 15'h7bff, 15'h0000, 8'hfc, 1'b1);
      `CHK(v, REF)
      do_reset;
      key;
      wr(8'h03, 8'h03);
      wr(8'h00, 8'h01);
      acc(1'b0, 2'h1, 15'h7bff, 15'h0000, 8'hfc, 1'b1);
      `CHK(v, GO)
      acc(1'b1, 2'h0, 15'h0400, 15'h0000, 8'h00, 1'b1);
      `CHK(v, GO)
      do_reset;
      rd(8'h04);
      `CHK(rv, 8'hfc)
      acc(1'b1, 2'h0, 15'h0800, 15'h0000, 8'h00, 1'b1);
      `CHK(v, REF)
      acc(1'b1, 2'h0, 15'h0c00, 15'h0000, 8'h00, 1'b1);
      `CHK(v, GO)
      acc(1'b1, 2'h0, 15'h7bff, 15'h0000, 8'h00, 1'b1);
      `CHK(v, REF)
      acc(1'b0, 2'h0, 15'h0400, 15'h1400, 8'h00, 1'b1);
      `CHK(v, FLT)
      acc(1'b0, 2'h0, 15'h0400, 15'h0000, 8'h00, 1'b1);
      `CHK(v, GO)
      acc(1'b1, 2'h3, 15'h0000, 15'h0000, 8'h00, 1'b1);
      `CHK(v, GO)
      do_reset;
      rd(8'h04);
      `CHK(rv, 8'hff)
    end
  endtask
  initial begin
    repeat (20) tick;
    rst_b_in <= 1'b1;
    repeat (4) tick;
    t_regs;
    t_busy;
    t_wen;
    t_erase;
    t_mon;
    t_lock;
    conclude;
  end
endmodule
